// [design/fsp_pkg.sv]
// Shared constants for the flash status and sector protect host controller
package fsp_pkg;
    // Register offsets (byte addresses on APB)
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    // Status fields
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_DONE_BIT   = 1;
    localparam int ST_FAIL_BIT   = 2;
    localparam int ST_ACCEPT_BIT = 3;
    localparam int ST_PROT_BIT   = 4;
    localparam int ST_RDATA_LSB  = 8;
    // Reset values
    localparam logic [18:0] ADDR_RST  = 19'h00000;
    localparam logic [7:0]  WDATA_RST = 8'h00;
    // Flash pin bits that the special modes use
    localparam int PIN_A0  = 0;
    localparam int PIN_A1  = 1;
    localparam int PIN_A6  = 6;
    localparam int PIN_A12 = 12;
    localparam int PIN_A16 = 16;
    localparam int DQ_FAIL = 5;
    localparam int DQ_TOG  = 6;
    localparam int DQ_POLL = 7;
    localparam int DQ_TMR  = 3;
    localparam logic [7:0] VERIFY_PROT = 8'h01;
    localparam logic [2:0] SEC_LAST    = 3'h7;
    // Timing
    localparam int CLK_NS      = 5;
    localparam int T_SETUP_NS  = 20;
    localparam int T_ACC_NS    = 120;
    localparam int T_WP_NS     = 50;
    localparam int T_REC_NS    = 30;
    localparam int T_PROT_US   = 100;
    localparam int T_UNPR_MS   = 10;
    localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC     = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_CYC     = (T_REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROT_CYC    = (T_PROT_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int UNPR_CYC    = (T_UNPR_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W       = 21;
    // Operation codes written to REG_CMD
    typedef enum logic [2:0] {
        OP_READ  = 3'h0, OP_WRITE = 3'h1, OP_DPOLL = 3'h2, OP_TPOLL  = 3'h3,
        OP_SADD  = 3'h4, OP_PROT  = 3'h5, OP_UNPR  = 3'h6, OP_VERIFY = 3'h7
    } fsp_op_e;
    // Bus access kinds
    typedef enum logic [1:0] {
        AC_RD = 2'h0, AC_WR = 2'h1, AC_PROT = 2'h2, AC_UNPR = 2'h3
    } fsp_acc_e;
    // Sequencer states, Gray along IDLE-SET-STB-REC
    typedef enum logic [1:0] {
        S_IDLE = 2'b00, S_SET = 2'b01, S_STB = 2'b11, S_REC = 2'b10
    } fsp_state_e;
endpackage : fsp_pkg

// [design/fsp_host_ctrl.sv]
// Host controller driving a byte-wide flash: status polling and sector protect
// Contract
// - Host polls erase status inside erased sector, address stable throughout.
// - After bit 7 or 6 shows completion, host does one more read.
// - Host reads bit 3 before and after added sector; both low accepts.
// - Protect: write high, select low, A9 and output at high voltage, 100 us; the controller drives write low for the 100 us pulse.
// - Unprotect: A9, output, select high voltage, A6 A12 A16 high, 10 ms.
// - Host protects every sector before running unprotect.
`timescale 1ns/100ps
`default_nettype none
module fsp_host_ctrl
    import fsp_pkg::*;
#(
    parameter int PROT_CYCLES = fsp_pkg::PROT_CYC,
    parameter int UNPR_CYCLES = fsp_pkg::UNPR_CYC
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Flash pins
    output logic [18:0]      fl_addr,
    input  wire logic [7:0]  fl_dq_i,
    output logic [7:0]       fl_dq_o,
    output logic             fl_dq_oe,
    output logic             fl_ce_n,
    output logic             fl_oe_n,
    output logic             fl_we_n,
    // High-voltage select levels for A9, output drive and chip select
    output logic             high_voltage_select_level_a9,
    output logic             high_voltage_select_level_oe,
    output logic             high_voltage_select_level_ce
);
    import fsp_pkg::*;

    logic             wr_en;
    logic             start;
    logic [18:0]      addr_r, addr_nxt;
    logic [7:0]       wdata_r, wdata_nxt;
    fsp_state_e       st_r, st_nxt;
    fsp_op_e          op_r, op_nxt;
    fsp_acc_e         acc_r, acc_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt, stb_len;
    logic [18:0]      pa_r, pa_nxt;
    logic [7:0]       rd_r, rd_nxt;
    logic [2:0]       sec_r, sec_nxt;
    logic [1:0]       ph_r, ph_nxt;
    logic             final_r, final_nxt, chk5_r, chk5_nxt, have_r, have_nxt;
    logic             prev6_r, prev6_nxt, b3a_r, b3a_nxt;
    logic             done_r, done_nxt, fail_r, fail_nxt;
    logic             acpt_r, acpt_nxt, prot_r, prot_nxt, settled;

    // Pin address for each access kind
    function automatic logic [18:0] pin_addr(fsp_op_e op, fsp_acc_e acc,
                                             logic [18:0] a, logic [2:0] sec);
        logic [18:0] r;
        r = a;
        if (acc == AC_PROT && op == OP_UNPR)
            r = {sec, a[15:0]};
        else if (acc == AC_UNPR)
        begin
            r[PIN_A6]  = 1'b1;
            r[PIN_A12] = 1'b1;
            r[PIN_A16] = 1'b1;
        end
        else if (op == OP_VERIFY)
        begin
            r[PIN_A0] = 1'b0;
            r[PIN_A6] = 1'b0;
            r[PIN_A1] = 1'b1;
        end
        return r;
    endfunction : pin_addr

    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign start   = wr_en && paddr == REG_CMD && st_r == S_IDLE;
    assign pslverr = psel && penable && !(paddr == REG_CMD || paddr == REG_ADDR
                     || paddr == REG_WDATA || paddr == REG_STATUS);

    always_comb
    begin
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        prdata    = 32'h0000_0000;
        if (wr_en && paddr == REG_ADDR && st_r == S_IDLE)
            addr_nxt = pwdata[18:0];
        if (wr_en && paddr == REG_WDATA && st_r == S_IDLE)
            wdata_nxt = pwdata[7:0];
        unique case (paddr)
            REG_CMD:    prdata[2:0] = op_r;
            REG_ADDR:   prdata[18:0] = addr_r;
            REG_WDATA:  prdata[7:0] = wdata_r;
            REG_STATUS:
            begin
                prdata[ST_BUSY_BIT]   = st_r != S_IDLE;
                prdata[ST_DONE_BIT]   = done_r;
                prdata[ST_FAIL_BIT]   = fail_r;
                prdata[ST_ACCEPT_BIT] = acpt_r;
                prdata[ST_PROT_BIT]   = prot_r;
                prdata[ST_RDATA_LSB +: 8] = rd_r;
            end
            default:    prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            addr_r  <= ADDR_RST;
            wdata_r <= WDATA_RST;
        end
        else
        begin
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // Strobe width per access; the high-voltage pulses dominate op time
    always_comb
    begin
        unique case (acc_r)
            AC_RD:   stb_len = CNT_W'(ACC_CYC);
            AC_WR:   stb_len = CNT_W'(WP_CYC);
            AC_PROT: stb_len = CNT_W'(PROT_CYCLES);
            AC_UNPR: stb_len = CNT_W'(UNPR_CYCLES);
        endcase
    end

    // Completion as seen by the polling method in use
    assign settled = (op_r == OP_DPOLL) ? rd_r[DQ_POLL] == wdata_r[DQ_POLL]
                                        : have_r && rd_r[DQ_TOG] == prev6_r;

    always_comb
    begin
        st_nxt = st_r;   op_nxt = op_r;   acc_nxt = acc_r;   cnt_nxt = cnt_r;
        pa_nxt = pa_r;   rd_nxt = rd_r;   sec_nxt = sec_r;   ph_nxt = ph_r;
        final_nxt = final_r;   chk5_nxt = chk5_r;   have_nxt = have_r;
        prev6_nxt = prev6_r;   b3a_nxt = b3a_r;     done_nxt = done_r;
        fail_nxt = fail_r;     acpt_nxt = acpt_r;   prot_nxt = prot_r;
        unique case (st_r)
            S_IDLE:
                if (start)
                begin
                    op_nxt = fsp_op_e'(pwdata[2:0]);
                    unique case (fsp_op_e'(pwdata[2:0]))
                        OP_WRITE: acc_nxt = AC_WR;
                        OP_PROT:  acc_nxt = AC_PROT;
                        OP_UNPR:  acc_nxt = AC_PROT;
                        default:  acc_nxt = AC_RD;
                    endcase
                    // Polls keep this address for the whole operation
                    pa_nxt = pin_addr(op_nxt, acc_nxt, addr_r, 3'h0);
                    st_nxt = S_SET;   cnt_nxt = '0;   sec_nxt = 3'h0;
                    ph_nxt = 2'h0;    final_nxt = 1'b0;   chk5_nxt = 1'b0;
                    have_nxt = 1'b0;  done_nxt = 1'b0;    fail_nxt = 1'b0;
                    acpt_nxt = 1'b0;  prot_nxt = 1'b0;
                end
            S_SET:
                if (cnt_r == CNT_W'(SETUP_CYC - 1))
                begin
                    st_nxt = S_STB;
                    cnt_nxt = '0;
                end
                else
                    cnt_nxt = cnt_r + 1'b1;
            S_STB:
                if (cnt_r == stb_len - 1'b1)
                begin
                    if (acc_r == AC_RD)
                        rd_nxt = fl_dq_i;
                    st_nxt = S_REC;
                    cnt_nxt = '0;
                end
                else
                    cnt_nxt = cnt_r + 1'b1;
            S_REC:
                if (cnt_r != CNT_W'(REC_CYC - 1))
                    cnt_nxt = cnt_r + 1'b1;
                else
                begin
                    cnt_nxt = '0;
                    st_nxt = S_SET;
                    done_nxt = 1'b0;
                    unique case (op_r)
                        OP_DPOLL, OP_TPOLL:
                        begin
                            have_nxt  = 1'b1;
                            prev6_nxt = rd_r[DQ_TOG];
                            // Status may settle ahead of data: one more read
                            if (final_r)
                            begin
                                fail_nxt = chk5_r && !settled;
                                done_nxt = 1'b1;
                            end
                            else if (settled)
                                final_nxt = 1'b1;
                            else if (rd_r[DQ_FAIL])
                            begin
                                final_nxt = 1'b1;
                                chk5_nxt = 1'b1;
                            end
                        end
                        OP_SADD:
                        begin
                            ph_nxt = ph_r + 2'h1;
                            if (ph_r == 2'h0)
                            begin
                                b3a_nxt = rd_r[DQ_TMR];
                                acc_nxt = AC_WR;
                            end
                            else if (ph_r == 2'h1)
                                acc_nxt = AC_RD;
                            else
                            begin
                                acpt_nxt = !b3a_r && !rd_r[DQ_TMR];
                                done_nxt = 1'b1;
                            end
                        end
                        OP_UNPR:
                            // Every sector is protected first, then all cleared
                            if (ph_r == 2'h0 && sec_r != SEC_LAST)
                                sec_nxt = sec_r + 3'h1;
                            else if (ph_r == 2'h0)
                            begin
                                ph_nxt = 2'h1;
                                acc_nxt = AC_UNPR;
                            end
                            else
                                done_nxt = 1'b1;
                        default:
                        begin
                            prot_nxt = rd_r == VERIFY_PROT;
                            done_nxt = 1'b1;
                        end
                    endcase
                    if (done_nxt)
                        st_nxt = S_IDLE;
                    pa_nxt = pin_addr(op_r, acc_nxt, addr_r, sec_nxt);
                end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_r <= S_IDLE;   op_r <= OP_READ;   acc_r <= AC_RD;   cnt_r <= '0;
            pa_r <= 19'h00000;   rd_r <= 8'h00;  sec_r <= 3'h0;    ph_r <= 2'h0;
            final_r <= 1'b0;  chk5_r <= 1'b0;    have_r <= 1'b0;   prev6_r <= 1'b0;
            b3a_r <= 1'b0;    done_r <= 1'b0;    fail_r <= 1'b0;   acpt_r <= 1'b0;
            prot_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;   op_r <= op_nxt;    acc_r <= acc_nxt; cnt_r <= cnt_nxt;
            pa_r <= pa_nxt;   rd_r <= rd_nxt;    sec_r <= sec_nxt; ph_r <= ph_nxt;
            final_r <= final_nxt;  chk5_r <= chk5_nxt;  have_r <= have_nxt;
            prev6_r <= prev6_nxt;  b3a_r <= b3a_nxt;    done_r <= done_nxt;
            fail_r <= fail_nxt;    acpt_r <= acpt_nxt;  prot_r <= prot_nxt;
        end
    end

    // Pin drive; levels held from SET through STB so strobes never glitch
    assign fl_addr  = pa_r;
    assign fl_dq_o  = wdata_r;
    assign fl_dq_oe = st_r != S_IDLE && acc_r == AC_WR;
    assign fl_ce_n  = !(st_r == S_SET || st_r == S_STB);
    assign fl_oe_n  = !(st_r == S_STB && acc_r == AC_RD);
    assign fl_we_n  = !(st_r == S_STB && acc_r != AC_RD);
    assign high_voltage_select_level_a9 = st_r != S_IDLE
        && (acc_r == AC_PROT || acc_r == AC_UNPR || op_r == OP_VERIFY);
    assign high_voltage_select_level_oe = st_r != S_IDLE
        && (acc_r == AC_PROT || acc_r == AC_UNPR);
    assign high_voltage_select_level_ce = st_r != S_IDLE && acc_r == AC_UNPR;

    // Checking helpers: write-low length and sectors protected in this op
    logic [CNT_W:0] wl_r, wl_nxt;
    logic [7:0]     pm_r, pm_nxt;
    always_comb
    begin
        wl_nxt = fl_we_n ? '0 : wl_r + 1'b1;
        pm_nxt = start ? 8'h00 : pm_r;
        if (st_r == S_STB && st_nxt == S_REC && acc_r == AC_PROT)
            pm_nxt[pa_r[18:16]] = 1'b1;
    end
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wl_r <= '0;
            pm_r <= 8'h00;
        end
        else
        begin
            wl_r <= wl_nxt;
            pm_r <= pm_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_POLL_ADDR_STABLE: assert property (
        st_r != S_IDLE && $past(st_r) != S_IDLE && (op_r == OP_DPOLL || op_r == OP_TPOLL)
        |-> $stable(fl_addr)) else $error("poll address moved");
    AST_FINAL_READ: assert property (
        $rose(done_r) && (op_r == OP_DPOLL || op_r == OP_TPOLL) |-> $past(final_r)
        && $past(acc_r) == AC_RD) else $error("poll ended without extra read");
    AST_SADD_ACCEPT: assert property (
        $rose(acpt_r) |-> !b3a_r && !rd_r[DQ_TMR]) else $error("bad sector accept");
    AST_SADD_THREE: assert property (
        $rose(done_r) && op_r == OP_SADD |-> $past(ph_r) == 2'h2)
        else $error("sector add missed a read");
    AST_PROT_LEVELS: assert property (
        !fl_we_n && acc_r == AC_PROT |-> high_voltage_select_level_a9
        && high_voltage_select_level_oe && !fl_ce_n && !high_voltage_select_level_ce)
        else $error("protect levels wrong");
    AST_PROT_WIDTH: assert property (
        // Count holds its final length in the same cycle that the strobe is first seen high
        $rose(fl_we_n) && $past(acc_r) == AC_PROT |-> wl_r == (CNT_W+1)'(PROT_CYCLES))
        else $error("protect pulse width wrong");
    AST_UNPR_LEVELS: assert property (
        !fl_we_n && high_voltage_select_level_ce |-> high_voltage_select_level_a9
        && high_voltage_select_level_oe && fl_addr[PIN_A6] && fl_addr[PIN_A12]
        && fl_addr[PIN_A16]) else $error("unprotect levels wrong");
    AST_UNPR_WIDTH: assert property (
        $rose(fl_we_n) && $past(acc_r) == AC_UNPR |-> wl_r == (CNT_W+1)'(UNPR_CYCLES))
        else $error("unprotect pulse width wrong");
    AST_UNPR_AFTER_ALL: assert property (
        $fell(fl_we_n) && acc_r == AC_UNPR |-> pm_r == 8'hFF)
        else $error("unprotect before all sectors protected");

    COV_DPOLL: cover property ($rose(done_r) && op_r == OP_DPOLL);
    COV_TPOLL_FAIL: cover property ($rose(fail_r) && op_r == OP_TPOLL);
    COV_SADD_OK: cover property ($rose(acpt_r));
    COV_UNPR: cover property ($rose(done_r) && op_r == OP_UNPR);
endmodule : fsp_host_ctrl
`default_nettype wire

// [tb/fsp_flash_model.sv]
// Behavioural model of the byte-wide flash that the host controller drives
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model #(
    parameter int BUSY_RD = 3,
    parameter int LOAD_RD = 4
)(
    // Restart of the device
    input  wire logic        rstn,
    // Parallel bus
    input  wire logic [18:0] addr,
    input  wire logic [7:0]  dq_in,
    output logic      [7:0]  dq_out,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    // High-voltage levels on A9, output drive and chip select
    input  wire logic        hv_a9,
    input  wire logic        hv_oe,
    input  wire logic        hv_ce
);
    logic [7:0]  mem [0:524287];
    logic [7:0]  prot, er_sec, pdata, last, val;
    logic [18:0] pa;
    logic [1:0]  mode;
    logic        tog, fail, susp, skip, fell;
    int          busy, load;
    realtime     t_fall;
    initial
    begin
        for (int i = 0; i < 524288; i++)
            mem[i] = 8'hFF;
        prot = 8'h00;
        last = 8'h00;
        t_fall = 0.0;
        // Strobes already low at power-up: first rising edge is no command
        skip = (ce_n === 1'b0) && (we_n === 1'b0) && (oe_n === 1'b1);
        forever
        begin
            // Read mode at power-up and after every restart
            mode = 2'd0;
            fail = 1'b0;
            tog = 1'b0;
            susp = 1'b0;
            fell = 1'b0;
            busy = 0;
            load = 0;
            er_sec = 8'h00;
            @(negedge rstn);
        end
    end
    // Only a real fall arms a cycle; the power-on rise of the strobe never does
    always @(negedge we_n)
    begin
        fell = 1'b1;
        t_fall = $realtime;
        if (load > 0)
            load = LOAD_RD;
    end
    always @(posedge we_n)
    begin
        if (!fell || skip || $realtime - t_fall < 5.0)
            skip = 1'b0;
        else if (hv_a9 && hv_oe && !hv_ce)
            prot[addr[18:16]] = 1'b1;
        else if (hv_a9 && hv_oe && hv_ce && addr[6] && addr[12] && addr[16])
            prot = 8'h00;
        else if (dq_in == 8'hB0 && mode == 2'd2)
        begin
            susp = 1'b1;
            load = 0;
        end
        else if (dq_in == 8'h30 && susp)
        begin
            susp = 1'b0;
            fail = 1'b0;
        end
        else if (dq_in == 8'h30 && (mode == 2'd0 || (mode == 2'd2 && load > 0)))
        begin
            mode = 2'd2;
            if (!prot[addr[18:16]])
                er_sec[addr[18:16]] = 1'b1;
            load = LOAD_RD;
            busy = BUSY_RD + LOAD_RD;
        end
        else if (mode == 2'd0)
        begin
            mode = 2'd1;
            pa = addr;
            pdata = dq_in;
            busy = BUSY_RD;
            fail = !prot[addr[18:16]] && (|(~mem[addr] & dq_in));
        end
        fell = 1'b0;
    end
    always @*
        if (hv_a9)
            val = {7'h00, prot[addr[18:16]]};
        else if (mode == 2'd1)
            val = {~pdata[7], tog, fail, 5'h00};
        else if (mode == 2'd2)
            val = {1'b0, tog, fail, 1'b0, load == 0, 3'h0};
        else
            val = mem[addr];
    // Released bus shows the inverse of the last byte, never a held copy
    assign dq_out = (!ce_n && !oe_n) ? val : ~last;
    always @(posedge oe_n)
    begin
        last = val;
        if (mode != 2'd0 && !susp)
        begin
            tog = ~tog;
            busy = (busy > 0) ? busy - 1 : 0;
            load = (load > 0) ? load - 1 : 0;
            if (busy == 0 && !fail && mode == 2'd1 && !prot[pa[18:16]])
                mem[pa] = mem[pa] & pdata;
            if (busy == 0 && !fail && mode == 2'd2)
                for (int i = 0; i < 524288; i++)
                    if (er_sec[i >> 16])
                        mem[i] = 8'hFF;
            // A failed operation keeps toggling until the device restarts
            if (busy == 0 && !fail)
                mode = 2'd0;
            if (busy == 0 && !fail)
                er_sec = 8'h00;
        end
    end
endmodule : fsp_flash_model
`default_nettype wire

// [tb/test_flash_status_and_sector_protect.sv]
// Self-checking bench for the flash status and sector protect host controller
`timescale 1ns/100ps
`default_nettype none
module test_flash_status_and_sector_protect;
    import fsp_pkg::*;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, fl_dq_o, fl_dq_i, mdl_dq;
    logic [31:0] pwdata, prdata, rd, st;
    logic [18:0] fl_addr;
    logic        fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, hv_a9, hv_oe, hv_ce;
    int          n_mismatch, cmp_count;
    fsp_host_ctrl #(.PROT_CYCLES(8), .UNPR_CYCLES(8)) dut_u (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
        .high_voltage_select_level_a9(hv_a9), .high_voltage_select_level_oe(hv_oe),
        .high_voltage_select_level_ce(hv_ce));
    fsp_flash_model mdl_u (
        .rstn(rstn), .addr(fl_addr), .dq_in(fl_dq_i), .dq_out(mdl_dq), .ce_n(fl_ce_n),
        .oe_n(fl_oe_n), .we_n(fl_we_n), .hv_a9(hv_a9), .hv_oe(hv_oe), .hv_ce(hv_ce));
    assign fl_dq_i = fl_dq_oe ? fl_dq_o : mdl_dq;
    initial
    begin
        clk = 1'b0;
        forever
            #2.5 clk = ~clk;
    end
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_mismatch++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_idle;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end
        while (rd[ST_BUSY_BIT] !== 1'b0 && n < 2000);
        if (n >= 2000)
        begin
            n_mismatch++;
            final_report();
        end
        st = rd;
    endtask : wait_idle
    task automatic run_op(input logic [2:0] op);
        apb(1'b1, REG_CMD, {29'h0, op});
        wait_idle();
    endtask : run_op
    function automatic logic [31:0] est(input logic [7:0] d, input logic p, input logic f);
        return {16'h0, d, 3'h0, p, 1'b0, f, 1'b1, 1'b0};
    endfunction : est
    initial
    begin
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        // Idle registers, then one offset past the map
        for (int i = 1; i < 5; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset_read", rd, 32'h0);
            chk("slverr", {31'h0, err}, {31'h0, i == 4});
        end
        apb(1'b1, REG_ADDR, 32'h30000);
        run_op(OP_VERIFY);
        chk("verify_unprot", st, est(8'h00, 1'b0, 1'b0));
        run_op(OP_PROT);
        chk("prot_done", st & 32'h6, 32'h2);
        run_op(OP_VERIFY);
        chk("verify_prot", st, est(8'h01, 1'b1, 1'b0));
        // Program, with an address write refused while busy
        apb(1'b1, REG_ADDR, 32'h10);
        apb(1'b1, REG_WDATA, 32'h5A);
        apb(1'b1, REG_CMD, {29'h0, OP_WRITE});
        apb(1'b1, REG_ADDR, 32'h20);
        wait_idle();
        apb(1'b0, REG_ADDR, 32'h0);
        chk("addr_kept", rd, 32'h10);
        run_op(OP_DPOLL);
        chk("dpoll_prog", st, est(8'h5A, 1'b0, 1'b0));
        run_op(OP_WRITE);
        run_op(OP_TPOLL);
        chk("tpoll_prog", st, est(8'h5A, 1'b0, 1'b0));
        // A one over a zero runs into the pulse limit
        apb(1'b1, REG_WDATA, 32'hFF);
        run_op(OP_WRITE);
        run_op(OP_DPOLL);
        chk("dpoll_fail", st & 32'h6, 32'h6);
        run_op(OP_READ);
        chk("read_busy_fail", st & 32'h6, 32'h2);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        // Protected sector keeps its contents
        apb(1'b1, REG_ADDR, 32'h30000);
        apb(1'b1, REG_WDATA, 32'h00);
        run_op(OP_WRITE);
        run_op(OP_TPOLL);
        chk("tpoll_prot", st, est(8'hFF, 1'b0, 1'b0));
        // Erase of two sectors, the second added inside the load delay
        apb(1'b1, REG_ADDR, 32'h20000);
        run_op(OP_WRITE);
        // Program runs on only while polled; finish it before the erase
        run_op(OP_DPOLL);
        chk("dpoll_prog0", st, est(8'h00, 1'b0, 1'b0));
        apb(1'b1, REG_WDATA, 32'h30);
        run_op(OP_WRITE);
        apb(1'b1, REG_ADDR, 32'h10000);
        run_op(OP_SADD);
        chk("sadd_in_window", st & 32'hE, 32'hA);
        apb(1'b1, REG_ADDR, 32'h20000);
        apb(1'b1, REG_WDATA, 32'hFF);
        run_op(OP_DPOLL);
        chk("dpoll_erase", st, est(8'hFF, 1'b0, 1'b0));
        apb(1'b1, REG_WDATA, 32'h30);
        apb(1'b1, REG_ADDR, 32'h50000);
        run_op(OP_SADD);
        chk("sadd_late", st & 32'hE, 32'h2);
        run_op(OP_UNPR);
        chk("unprot_done", st & 32'h6, 32'h2);
        apb(1'b1, REG_ADDR, 32'h30000);
        run_op(OP_VERIFY);
        chk("verify_after_unprot", st, est(8'h00, 1'b0, 1'b0));
        final_report();
    end
endmodule : test_flash_status_and_sector_protect
`default_nettype wire
